// ---- design/sscf_pkg.sv ----
/*
  sscf_pkg: constants and types shared by the serial status flag block.
  Assumes a 10 MHz peripheral clock and a fixed line bit rate.
*/
package sscf_pkg;

  // clock and line timing
  localparam int unsigned CLK_HZ      = 10_000_000;
  localparam int unsigned BIT_RATE_HZ = 9600;
  localparam int unsigned OS_PER_BIT  = 16;
  localparam int unsigned OS_DIV      = CLK_HZ / (BIT_RATE_HZ * OS_PER_BIT);
  localparam logic [6:0]  OS_DIV_LAST = 7'(OS_DIV - 1);
  localparam logic [3:0]  OS_LAST     = 4'(OS_PER_BIT - 1);
  localparam logic [3:0]  OS_MID      = 4'(OS_PER_BIT / 2 - 1);

  // wishbone byte addresses
  localparam logic [3:0]  ADR_STATUS  = 4'h0;
  localparam logic [3:0]  ADR_CONTROL = 4'h4;
  localparam logic [3:0]  ADR_TXDATA  = 4'h8;
  localparam logic [3:0]  ADR_RXDATA  = 4'hc;

  // status register layout
  localparam logic [7:0]  STATUS_RESET = 8'h84;
  localparam int          B_TX_EMPTY   = 7;
  localparam int          B_TX_MP      = 0;
  localparam int          FLAG_LO      = 3;
  localparam int          NUM_FLAGS    = 5;
  // index into the clear-after-read flag vector (status bit = FLAG_LO + index)
  localparam int          F_PER        = 0;
  localparam int          F_FER        = 1;
  localparam int          F_OVERRUN_FLAG       = 2;
  localparam int          F_RX_HOLDING_FULL_FLAG       = 3;
  localparam int          F_TX_HOLDING_EMPTY_FLAG       = 4;

  // control register layout
  localparam int          C_TX_EN      = 0;
  localparam int          C_RX_EN      = 1;
  localparam int          C_SYNC       = 2;
  localparam int          C_TWO_STOP   = 3;
  localparam int          C_PAR_EN     = 4;
  localparam int          C_PAR_ODD    = 5;
  localparam int          C_MP_EN      = 6;
  localparam int          C_STANDBY    = 7;
  localparam int          C_MSTANDBY   = 8;
  localparam int          CTRL_W       = 9;

  // character frame
  localparam logic [3:0]  FRAME_BASE   = 4'h9;
  localparam logic [3:0]  TX_BITS_BASE = 4'ha;

  typedef enum logic [0:0] {
    SSCF_TX_IDLE  = 1'b0,
    SSCF_TX_SHIFT = 1'b1
  } sscf_tx_state_t;

  typedef enum logic [0:0] {
    SSCF_RX_IDLE = 1'b0,
    SSCF_RX_BITS = 1'b1
  } sscf_rx_state_t;

endpackage

// ---- design/sscf_sync3.sv ----
/*
  sscf_sync3: three-flop input synchroniser with agreement filter.
  Assumes an asynchronous level input; output idles at the given level.
*/
`timescale 1ns/1ps
module sscf_sync3 #(
  parameter logic IDLE = 1'b1
) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic d_i,
  output logic      q_o
);

  typedef struct packed {
    logic s1;
    logic s2;
    logic s3;
    logic q;
  } sscf_sync_t;

  sscf_sync_t r;
  sscf_sync_t n;

  always_comb
  begin
    n    = r;
    n.s1 = d_i;
    n.s2 = r.s1;
    n.s3 = r.s2;
    // a change counts only once the second and third stages agree
    if (r.s2 == r.s3)
    begin
      n.q = r.s3;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      r <= {IDLE, IDLE, IDLE, IDLE};
    end
    else
    begin
      r <= n;
    end
  end

  assign q_o = r.q;

endmodule

// ---- design/sscf_flag_cell.sv ----
/*
  sscf_flag_cell: one hardware-set status flag, cleared by read-then-write-zero.
  Assumes rd_i pulses when software samples the flag and wr_i when it writes it.
*/
`timescale 1ns/1ps
module sscf_flag_cell #(
  parameter logic INIT = 1'b0
) (
  input  wire logic clk_i,
  input  wire logic init_i,
  input  wire logic set_i,
  input  wire logic rd_i,
  input  wire logic wr_i,
  input  wire logic wdata_i,
  output logic      flag_o,
  output logic      armed_o
);

  typedef struct packed {
    logic flag;
    logic armed;
  } sscf_cell_t;

  sscf_cell_t r;
  sscf_cell_t n;

  always_comb
  begin
    n = r;
    if (rd_i && r.flag)
    begin
      n.armed = 1'b1;
    end
    // writing one does nothing; zero clears only once a set value was read
    if (wr_i && !wdata_i && r.armed && r.flag)
    begin
      n.flag  = 1'b0;
      n.armed = 1'b0;
    end
    if (set_i)
    begin
      n.flag = 1'b1;
    end
    if (init_i)
    begin
      n.flag  = INIT;
      n.armed = 1'b0;
    end
  end

  always_ff @(posedge clk_i)
  begin
    r <= n;
  end

  assign flag_o  = r.flag;
  assign armed_o = r.armed;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (init_i);

  sequence s_armed_clear;
    armed_o && flag_o && wr_i && !wdata_i && !set_i;
  endsequence

  a_armed_clear: assert property (s_armed_clear |=> !flag_o)
    else $error("armed zero write did not clear flag");
  a_one_no_effect: assert property ((wr_i && wdata_i && !set_i && !flag_o) |=> !flag_o)
    else $error("writing one changed a clear flag");
  a_unread_holds: assert property ((flag_o && !armed_o && !rd_i) |=> flag_o)
    else $error("unread flag was cleared");
  a_set_wins: assert property (set_i |=> flag_o)
    else $error("set event lost against a clear");

endmodule

// ---- design/sscf_serial_status.sv ----
/*
  sscf_serial_status: status flag logic of a serial channel with a small
  line transmitter and receiver, reached over a classic wishbone slave.
  Assumes a 10 MHz clock, synchronous active-high reset, and an idle-high line.
*/
`timescale 1ns/1ps
// Behaviour
// - status register returns to 0x84 on reset, standby or module standby.
// - writing one to the five flags does nothing; zero clears only after a read.
// - transmit-done and received multiprocessor bits ignore writes.
// - transmit-empty sets on reset/standby, transmitter disable, or holding-to-shift transfer.
// - transmit-empty zero means holding data pending; one means software may write.
// - receive-full sets when an error-free character moves into the holding register.
// - receive errors leave receive-full untouched, though framing and parity errors still move the data; receiver disable leaves both untouched.
// - overrun sets when a character completes while receive-full is one; it is dropped.
// - overrun halts reception, and in synchronous mode transmission too.
// - receiver disable keeps overrun and framing flags as they were.
// - asynchronous framing error sets when the checked stop bit samples zero.
// - with two stop bits only the first is checked.
// - framing error still moves the character but leaves receive-full clear.
// - framing error halts reception, and in synchronous mode transmission too.
// - parity error sets when ones in data plus parity mismatch the selected parity.
// - transmit multiprocessor bit is plain read/write, reset to zero.
// - transmit-done sets at last bit with transmit-empty one, and on reset or disable.
// - transmit-done clears when transmit-empty is read set then written zero.
// - parity error moves the character without receive-full and halts reception.
module sscf_serial_status (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic        rxd_i,
  output logic             wb_ack_o,
  output logic [31:0]      wb_dat_o,
  output logic             txd_o
);

  typedef struct packed {
    logic                     ack;
    logic [31:0]              dat;
    logic [sscf_pkg::CTRL_W-1:0] ctrl;
    logic [7:0]               tx_hold;
    logic [7:0]               rx_hold;
    logic                     tx_done_flag;
    logic                     rx_multiproc_flag;
    logic                     tx_multiproc_value;
    logic                     txd;
    sscf_pkg::sscf_tx_state_t tx_state;
    logic [11:0]              tx_shift;
    logic [3:0]               tx_bits;
    logic [3:0]               tx_os;
    sscf_pkg::sscf_rx_state_t rx_state;
    logic [3:0]               rx_os;
    logic [3:0]               rx_idx;
    logic [11:0]              rx_shift;
    logic [6:0]               div;
    logic                     os_tick;
  } sscf_state_t;

  sscf_state_t r;
  sscf_state_t n;

  logic [sscf_pkg::NUM_FLAGS-1:0] flag;
  logic [sscf_pkg::NUM_FLAGS-1:0] armed;
  logic [sscf_pkg::NUM_FLAGS-1:0] flag_set;
  logic [7:0]  status;
  logic        rxd_s;
  logic        init;
  logic        req;
  logic        wr_acc;
  logic        st_rd;
  logic        st_wr;
  logic        tx_en;
  logic        rx_en;
  logic        par_en;
  logic        mp_en;
  logic        sync_md;
  logic        err_any;
  logic        tx_halt;
  logic        tx_load;
  logic        tx_tick;
  logic        tx_end;
  logic        tx_holding_empty_flag_clr;
  logic        rx_smp;
  logic [3:0]  rx_last;
  logic        rx_done;
  logic [7:0]  rx_data;
  logic        rx_mpbit;
  logic        par_bad;
  logic        stop_bad;
  logic        rx_move;
  logic        overrun;
  logic        fer_set;
  logic        per_set;
  logic        good;

  sscf_sync3 #(
    .IDLE (1'b1)
  ) u_rx_sync (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .d_i   (rxd_i),
    .q_o   (rxd_s)
  );

  // standby and module standby act as a held reset of the status logic
  assign init    = rst_i | r.ctrl[sscf_pkg::C_STANDBY] | r.ctrl[sscf_pkg::C_MSTANDBY];
  assign req     = wb_cyc_i & wb_stb_i;
  assign wr_acc  = req & r.ack & wb_we_i;
  assign st_rd   = req & ~r.ack & ~wb_we_i & (wb_adr_i == sscf_pkg::ADR_STATUS);
  assign st_wr   = wr_acc & (wb_adr_i == sscf_pkg::ADR_STATUS) & wb_sel_i[0];
  assign tx_en   = r.ctrl[sscf_pkg::C_TX_EN];
  assign rx_en   = r.ctrl[sscf_pkg::C_RX_EN];
  assign par_en  = r.ctrl[sscf_pkg::C_PAR_EN];
  assign mp_en   = r.ctrl[sscf_pkg::C_MP_EN] & ~sync_md;
  assign sync_md = r.ctrl[sscf_pkg::C_SYNC];
  assign status  = {flag, r.tx_done_flag, r.rx_multiproc_flag, r.tx_multiproc_value};

  assign err_any = flag[sscf_pkg::F_PER] | flag[sscf_pkg::F_FER] | flag[sscf_pkg::F_OVERRUN_FLAG];
  assign tx_halt = sync_md & err_any;
  // a frame starts only from pending holding data
  assign tx_load = (r.tx_state == sscf_pkg::SSCF_TX_IDLE) & tx_en & ~flag[sscf_pkg::F_TX_HOLDING_EMPTY_FLAG]
                   & ~tx_halt & ~init;
  assign tx_tick = r.os_tick & (r.tx_os == sscf_pkg::OS_LAST);
  assign tx_end  = (r.tx_state == sscf_pkg::SSCF_TX_SHIFT) & tx_en & tx_tick & (r.tx_bits == 4'h1);
  assign tx_holding_empty_flag_clr = st_wr & ~wb_dat_i[sscf_pkg::B_TX_EMPTY] & armed[sscf_pkg::F_TX_HOLDING_EMPTY_FLAG]
                    & flag[sscf_pkg::F_TX_HOLDING_EMPTY_FLAG];

  assign rx_smp   = r.os_tick & (r.rx_state == sscf_pkg::SSCF_RX_BITS) & (r.rx_os == sscf_pkg::OS_MID);
  // second stop bit is never sampled: the frame ends at the first
  assign rx_last  = 4'(sscf_pkg::FRAME_BASE + {3'h0, par_en} + {3'h0, mp_en});
  assign rx_done  = rx_smp & (r.rx_idx == rx_last) & rx_en & ~init;
  assign rx_data  = r.rx_shift[8:1];
  assign rx_mpbit = par_en ? r.rx_shift[10] : r.rx_shift[9];
  assign par_bad  = par_en & ((^rx_data ^ r.rx_shift[9]) != r.ctrl[sscf_pkg::C_PAR_ODD]);
  assign stop_bad = ~rxd_s & ~sync_md;
  assign rx_move  = rx_done & ~flag[sscf_pkg::F_RX_HOLDING_FULL_FLAG];
  assign overrun  = rx_done & flag[sscf_pkg::F_RX_HOLDING_FULL_FLAG];
  assign fer_set  = rx_move & stop_bad;
  assign per_set  = rx_move & par_bad;
  assign good     = rx_move & ~stop_bad & ~par_bad;

  assign flag_set[sscf_pkg::F_TX_HOLDING_EMPTY_FLAG] = tx_load | ~tx_en;
  assign flag_set[sscf_pkg::F_RX_HOLDING_FULL_FLAG] = good;
  assign flag_set[sscf_pkg::F_OVERRUN_FLAG] = overrun;
  assign flag_set[sscf_pkg::F_FER]  = fer_set;
  assign flag_set[sscf_pkg::F_PER]  = per_set;

  genvar gi;
  generate
    for (gi = 0; gi < sscf_pkg::NUM_FLAGS; gi = gi + 1)
    begin : g_flag
      sscf_flag_cell #(
        .INIT (sscf_pkg::STATUS_RESET[sscf_pkg::FLAG_LO + gi])
      ) u_cell (
        .clk_i   (clk_i),
        .init_i  (init),
        .set_i   (flag_set[gi]),
        .rd_i    (st_rd),
        .wr_i    (st_wr),
        .wdata_i (wb_dat_i[sscf_pkg::FLAG_LO + gi]),
        .flag_o  (flag[gi]),
        .armed_o (armed[gi])
      );
    end
  endgenerate

  always_comb
  begin
    logic [31:0] rd;
    logic [2:0]  tail;
    logic        tx_par;
    rd     = 32'h0;
    tail   = 3'h7;
    tx_par = (^r.tx_hold) ^ r.ctrl[sscf_pkg::C_PAR_ODD];
    n      = r;

    // wishbone slave: ack one cycle after the strobe, dropped the cycle after
    n.ack = req & ~r.ack;
    if (wb_adr_i == sscf_pkg::ADR_STATUS)
    begin
      rd = {24'h0, status};
    end
    else if (wb_adr_i == sscf_pkg::ADR_CONTROL)
    begin
      rd = {23'h0, r.ctrl};
    end
    else if (wb_adr_i == sscf_pkg::ADR_TXDATA)
    begin
      rd = {24'h0, r.tx_hold};
    end
    else if (wb_adr_i == sscf_pkg::ADR_RXDATA)
    begin
      rd = {24'h0, r.rx_hold};
    end
    n.dat = (req & ~r.ack & ~wb_we_i) ? rd : 32'h0;

    if (wr_acc && wb_adr_i == sscf_pkg::ADR_CONTROL)
    begin
      if (wb_sel_i[0])
      begin
        n.ctrl[7:0] = wb_dat_i[7:0];
      end
      if (wb_sel_i[1])
      begin
        n.ctrl[sscf_pkg::C_MSTANDBY] = wb_dat_i[sscf_pkg::C_MSTANDBY];
      end
    end
    else if (wr_acc && wb_adr_i == sscf_pkg::ADR_TXDATA && wb_sel_i[0])
    begin
      n.tx_hold = wb_dat_i[7:0];
    end
    // status writes reach the flag cells and the plain bit 0; bit 1 ignores them, bit 2 clears only with the transmit-empty clear
    if (st_wr)
    begin
      n.tx_multiproc_value = wb_dat_i[sscf_pkg::B_TX_MP];
    end

    // oversample divider: one enable pulse per sixteenth of a bit
    n.os_tick = (r.div == sscf_pkg::OS_DIV_LAST);
    n.div     = n.os_tick ? 7'h0 : r.div + 7'h1;

    // transmitter
    if (tx_holding_empty_flag_clr)
    begin
      n.tx_done_flag = 1'b0;
    end
    if (par_en && mp_en)
    begin
      tail = {1'b1, r.tx_multiproc_value, tx_par};
    end
    else if (par_en)
    begin
      tail = {2'h3, tx_par};
    end
    else if (mp_en)
    begin
      tail = {2'h3, r.tx_multiproc_value};
    end
    case (r.tx_state)
      sscf_pkg::SSCF_TX_IDLE:
      begin
        if (tx_load)
        begin
          n.tx_shift = {tail, r.tx_hold, 1'b0};
          n.txd      = 1'b0;
          n.tx_os    = 4'h0;
          n.tx_bits  = 4'(sscf_pkg::TX_BITS_BASE + {3'h0, par_en} + {3'h0, mp_en}
                          + {3'h0, r.ctrl[sscf_pkg::C_TWO_STOP]});
          n.tx_state = sscf_pkg::SSCF_TX_SHIFT;
        end
      end
      sscf_pkg::SSCF_TX_SHIFT:
      begin
        if (r.os_tick)
        begin
          n.tx_os = r.tx_os + 4'h1;
        end
        if (tx_end)
        begin
          n.txd      = 1'b1;
          n.tx_state = sscf_pkg::SSCF_TX_IDLE;
          if (flag[sscf_pkg::F_TX_HOLDING_EMPTY_FLAG])
          begin
            n.tx_done_flag = 1'b1;
          end
        end
        else if (tx_tick)
        begin
          n.txd      = r.tx_shift[1];
          n.tx_shift = {1'b1, r.tx_shift[11:1]};
          n.tx_bits  = r.tx_bits - 4'h1;
        end
      end
      default:
      begin
        n.tx_state = sscf_pkg::SSCF_TX_IDLE;
      end
    endcase
    if (!tx_en)
    begin
      n.tx_done_flag     = 1'b1;
      n.txd      = 1'b1;
      n.tx_state = sscf_pkg::SSCF_TX_IDLE;
    end

    // receiver; disabling it drops the frame in flight but never the flags
    case (r.rx_state)
      sscf_pkg::SSCF_RX_IDLE:
      begin
        // any error flag still set keeps the receiver parked
        if (rx_en && !err_any && !init && !rxd_s)
        begin
          n.rx_os    = 4'h0;
          n.rx_idx   = 4'h0;
          n.rx_state = sscf_pkg::SSCF_RX_BITS;
        end
      end
      sscf_pkg::SSCF_RX_BITS:
      begin
        if (r.os_tick)
        begin
          n.rx_os = r.rx_os + 4'h1;
        end
        if (rx_smp)
        begin
          n.rx_shift[r.rx_idx] = rxd_s;
          n.rx_idx             = r.rx_idx + 4'h1;
          if ((r.rx_idx == 4'h0 && rxd_s) || rx_done)
          begin
            n.rx_state = sscf_pkg::SSCF_RX_IDLE;
          end
        end
      end
      default:
      begin
        n.rx_state = sscf_pkg::SSCF_RX_IDLE;
      end
    endcase
    // an overrun character is dropped; errors alone never touch receive-full
    if (rx_move)
    begin
      n.rx_hold = rx_data;
      if (mp_en)
      begin
        n.rx_multiproc_flag = rx_mpbit;
      end
    end
    if (!rx_en)
    begin
      n.rx_state = sscf_pkg::SSCF_RX_IDLE;
    end

    if (init)
    begin
      n.tx_done_flag     = sscf_pkg::STATUS_RESET[2];
      n.rx_multiproc_flag      = sscf_pkg::STATUS_RESET[1];
      n.tx_multiproc_value     = sscf_pkg::STATUS_RESET[0];
      n.txd      = 1'b1;
      n.tx_state = sscf_pkg::SSCF_TX_IDLE;
      n.rx_state = sscf_pkg::SSCF_RX_IDLE;
    end
    if (rst_i)
    begin
      n      = '0;
      n.tx_done_flag = 1'b1;
      n.txd  = 1'b1;
    end
  end

  always_ff @(posedge clk_i)
  begin
    r <= n;
  end

  assign wb_ack_o = r.ack;
  assign wb_dat_o = r.dat;
  assign txd_o    = r.txd;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  sequence s_tx_holding_empty_flag_clear;
    tx_holding_empty_flag_clr && !tx_end && tx_en && !init;
  endsequence

  a_status_init: assert property (init |=> status == sscf_pkg::STATUS_RESET)
    else $error("status not at reset value after standby");
  a_mpb_readonly: assert property ((!rx_move && !init) |=> $stable(r.rx_multiproc_flag))
    else $error("received multiprocessor bit changed without reception");
  a_tx_holding_empty_flag_disable: assert property (!tx_en |=> flag[sscf_pkg::F_TX_HOLDING_EMPTY_FLAG])
    else $error("transmit empty not set while transmitter disabled");
  a_load_frame: assert property (tx_load |=> flag[sscf_pkg::F_TX_HOLDING_EMPTY_FLAG] && !r.txd && r.tx_state == sscf_pkg::SSCF_TX_SHIFT)
    else $error("holding transfer did not start a frame");
  a_good_rx: assert property (good |=> flag[sscf_pkg::F_RX_HOLDING_FULL_FLAG] && r.rx_hold == $past(rx_data))
    else $error("good character not latched with receive full");
  a_rx_off_keeps: assert property ((!rx_en && !init && !st_wr) |=> $stable(flag[sscf_pkg::F_RX_HOLDING_FULL_FLAG:0]))
    else $error("receiver disable altered receive flags");
  a_overrun_keep: assert property (overrun |=> flag[sscf_pkg::F_OVERRUN_FLAG] && $stable(r.rx_hold))
    else $error("overrun did not keep earlier data");
  a_rx_halted: assert property ((err_any && r.rx_state == sscf_pkg::SSCF_RX_IDLE) |=> r.rx_state == sscf_pkg::SSCF_RX_IDLE)
    else $error("reception restarted with an error flag set");
  a_sync_tx_halt: assert property ((sync_md && err_any) |-> !tx_load)
    else $error("synchronous transmit started with an error flag set");
  a_framing: assert property (fer_set |=> flag[sscf_pkg::F_FER] && !flag[sscf_pkg::F_RX_HOLDING_FULL_FLAG] && r.rx_hold == $past(rx_data))
    else $error("framing error handling wrong");
  a_parity: assert property (per_set |=> flag[sscf_pkg::F_PER] && !flag[sscf_pkg::F_RX_HOLDING_FULL_FLAG])
    else $error("parity error handling wrong");
  a_stop_end: assert property (rx_done |=> r.rx_state == sscf_pkg::SSCF_RX_IDLE)
    else $error("receiver waited beyond the first stop bit");
  a_tx_done_flag_set: assert property ((tx_end && flag[sscf_pkg::F_TX_HOLDING_EMPTY_FLAG]) |=> r.tx_done_flag)
    else $error("transmit done not set at frame end");
  a_tx_done_flag_clear: assert property (s_tx_holding_empty_flag_clear |=> !r.tx_done_flag)
    else $error("transmit done not cleared with transmit empty");
  a_tx_multiproc_value_rw: assert property ((st_wr && !init) |=> r.tx_multiproc_value == $past(wb_dat_i[sscf_pkg::B_TX_MP]))
    else $error("transmit multiprocessor bit not written");

endmodule

// ---- tb/sscf_remote_station.sv ----
/*
  sscf_remote_station: far-side serial station, sends 8-bit characters with an optional parity bit and captures 8n1 characters.
  Assumes an idle-high line and a fixed bit time in clock cycles.
*/
`timescale 1ns/1ps
module sscf_remote_station #(
  parameter int BIT_CYC = 1040
) (
  input  wire logic  clk_i,
  input  wire logic  txd_i,
  output logic       rxd_o,
  output logic [7:0] cap_byte_o,
  output logic [7:0] cap_cnt_o
);
  logic [7:0] sh;

  task automatic put_bit(input logic b);
    rxd_o <= b;
    repeat (BIT_CYC) @(posedge clk_i);
  endtask

  // par_bad flips even parity, stop_v low forces a framing fault
  task automatic send_char(input logic [7:0] d, input logic par_on, input logic par_bad, input logic stop_v);
    put_bit(1'b0);
    for (int i = 0; i < 8; i++)
      put_bit(d[i]);
    if (par_on)
      put_bit((^d) ^ par_bad);
    put_bit(stop_v);
    put_bit(1'b1);
  endtask

  initial
  begin
    rxd_o = 1'b1;
    cap_byte_o = 8'h00;
    cap_cnt_o = 8'h00;
    forever
    begin
      @(posedge clk_i);
      if (txd_i === 1'b0)
      begin
        // sample mid-bit so a one-cycle skew of the edge does not matter
        repeat (BIT_CYC / 2) @(posedge clk_i);
        for (int i = 0; i < 8; i++)
        begin
          repeat (BIT_CYC) @(posedge clk_i);
          sh[i] = txd_i;
        end
        repeat (BIT_CYC) @(posedge clk_i);
        if (txd_i === 1'b1)
        begin
          cap_byte_o <= sh;
          cap_cnt_o <= cap_cnt_o + 8'h01;
        end
      end
    end
  end
endmodule

// ---- tb/sscf_serial_status_tb.sv ----
/*
  sscf_serial_status_tb: register-level tests of the status flags over wishbone.
  Assumes the remote station model on the serial lines and a 10 MHz clock.
*/
`timescale 1ns/1ps
module sscf_serial_status_tb;
  localparam int BIT_CYC = sscf_pkg::OS_DIV * sscf_pkg::OS_PER_BIT;
  localparam logic [3:0] ST = sscf_pkg::ADR_STATUS;
  localparam logic [3:0] CT = sscf_pkg::ADR_CONTROL;
  localparam logic [3:0] RX = sscf_pkg::ADR_RXDATA;

  logic        clk_i;
  logic        rst_i;
  logic        wb_cyc_i;
  logic        wb_stb_i;
  logic        wb_we_i;
  logic [3:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i;
  logic        rxd_w;
  logic        wb_ack_o;
  logic [31:0] wb_dat_o;
  logic        txd_o;
  logic [31:0] rd;
  logic [7:0]  cap_byte;
  logic [7:0]  cap_cnt;
  logic [7:0]  cnt0;
  int          error_cnt;
  int          cmp_count;

  sscf_serial_status u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
    .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .rxd_i(rxd_w),
    .wb_ack_o(wb_ack_o), .wb_dat_o(wb_dat_o), .txd_o(txd_o)
  );

  sscf_remote_station #(.BIT_CYC(BIT_CYC)) u_remote (
    .clk_i(clk_i), .txd_i(txd_o), .rxd_o(rxd_w), .cap_byte_o(cap_byte), .cap_cnt_o(cap_cnt)
  );

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  task automatic stop_test();
    $display("counts: %0d compares, %0d mismatches", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // request held until ack is sampled high, for at most 20 cycles before a bus timeout
  task automatic wb_xfer(input logic we, input logic [3:0] adr, input logic [31:0] wd, output logic [31:0] rdat);
    int n;
    logic ok;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= adr;
    wb_sel_i <= 4'hf;
    wb_dat_i <= wd;
    n = 0;
    do
    begin
      @(posedge clk_i);
      n++;
      ok = (wb_ack_o === 1'b1);
    end while (!ok && n < 20);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
    @(posedge clk_i);
    if (!ok)
    begin
      error_cnt++;
      $display("mismatch at %0t: bus timeout", $time);
      stop_test();
    end
  endtask

  task automatic rd_chk(input logic [3:0] adr, input logic [31:0] exp, input string what);
    wb_xfer(1'b0, adr, 32'h0000_0000, rd);
    chk(rd, exp, what);
  endtask

  task automatic wr(input logic [3:0] adr, input logic [31:0] d);
    wb_xfer(1'b1, adr, d, rd);
  endtask

  initial
  begin
    rst_i = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 4'h0;
    wb_sel_i = 4'h0;
    wb_dat_i = 32'h0000_0000;
    error_cnt = 0;
    cmp_count = 0;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd_chk(ST, 32'h0000_0084, "status after reset");
    rd_chk(4'h2, 32'h0000_0000, "unmapped read");
    wr(ST, 32'h0000_00ff);
    rd_chk(ST, 32'h0000_0085, "ones written");
    wr(ST, 32'h0000_0080);
    rd_chk(ST, 32'h0000_0084, "tx multiproc cleared, done kept");
    $display("test registers done");
    wr(CT, 32'h0000_0003);
    wr(sscf_pkg::ADR_TXDATA, 32'h0000_00a5);
    cnt0 = cap_cnt;
    rd_chk(ST, 32'h0000_0084, "data pending, flag armed");
    wr(ST, 32'h0000_0000);
    rd_chk(ST, 32'h0000_0080, "loaded, sending");
    for (int n = 0; n < 20 * BIT_CYC && cap_cnt === cnt0; n++)
      @(posedge clk_i);
    if (cap_cnt === cnt0)
    begin
      error_cnt++;
      $display("mismatch at %0t: transmit timeout", $time);
      stop_test();
    end
    chk({24'h0, cap_byte}, 32'h0000_00a5, "line byte");
    repeat (BIT_CYC) @(posedge clk_i);
    rd_chk(ST, 32'h0000_0084, "transmit done");
    $display("test transmit done");
    u_remote.send_char(8'h3c, 1'b0, 1'b0, 1'b1);
    rd_chk(ST, 32'h0000_00c4, "receive full");
    rd_chk(RX, 32'h0000_003c, "rx data");
    u_remote.send_char(8'h55, 1'b0, 1'b0, 1'b1);
    rd_chk(ST, 32'h0000_00e4, "overrun");
    rd_chk(RX, 32'h0000_003c, "older data kept");
    wr(ST, 32'h0000_0080);
    rd_chk(ST, 32'h0000_0084, "flags cleared");
    u_remote.send_char(8'h96, 1'b0, 1'b0, 1'b0);
    rd_chk(ST, 32'h0000_0094, "framing");
    rd_chk(RX, 32'h0000_0096, "framing data moved");
    wr(ST, 32'h0000_0080);
    rd_chk(ST, 32'h0000_0084, "framing cleared");
    // multiproc format with two stop bits; the station's extra bit carries the multiproc value
    wr(CT, 32'h0000_004b);
    u_remote.send_char(8'h0f, 1'b1, 1'b1, 1'b1);
    rd_chk(ST, 32'h0000_00c6, "multiproc bit received");
    wr(ST, 32'h0000_0080);
    rd_chk(ST, 32'h0000_0086, "multiproc bit read-only");
    wr(CT, 32'h0000_0033);
    u_remote.send_char(8'h0f, 1'b1, 1'b1, 1'b1);
    rd_chk(ST, 32'h0000_00c6, "odd parity good");
    wr(ST, 32'h0000_0080);
    $display("test receive done");
    wr(CT, 32'h0000_0013);
    u_remote.send_char(8'h0f, 1'b1, 1'b1, 1'b1);
    rd_chk(ST, 32'h0000_008e, "parity");
    rd_chk(RX, 32'h0000_000f, "parity data moved");
    wr(CT, 32'h0000_0001);
    rd_chk(ST, 32'h0000_008e, "receiver off keeps flags");
    // synchronous mode: pending data must wait while the parity flag stands
    wr(CT, 32'h0000_0005);
    wr(ST, 32'h0000_0008);
    rd_chk(ST, 32'h0000_000a, "sync transmit held by error");
    wr(ST, 32'h0000_0080);
    rd_chk(ST, 32'h0000_0082, "sync transmit resumes");
    wr(CT, 32'h0000_0080);
    rd_chk(ST, 32'h0000_0084, "standby");
    wr(CT, 32'h0000_0000);
    wr(ST, 32'h0000_0081);
    rd_chk(ST, 32'h0000_0085, "tx multiproc set");
    wr(CT, 32'h0000_0100);
    rd_chk(ST, 32'h0000_0084, "module standby");
    $display("test errors done");
    stop_test();
  end
endmodule
